//--- rtl/pllpc_edge.sv
// rising edge detector stage for one comparator input
`timescale 1ns/1ps
module pllpc_edge (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic level_in,
    output logic rise_out
);
    import pllpc_pkg::*;
    logic last_q;

    // remember previous level; falling edges give nothing
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            last_q <= PLLPC_RESET_LEVEL;
        end else begin
            last_q <= level_in;
        end
    end

    assign rise_out = level_in & ~last_q;
endmodule

//--- rtl/pllpc_pkg.sv
// package of constants for the pll phase comparator block
// Summary of operation
// - comparator one outputs signal xor comparator
// - both comparators share signal and comparator inputs
// - comparator two uses four flip-flop stages
// - up drives high, down drives low, else float
// - comparator two acts on rising edges only
// - inhibit low enables oscillator, high stops it
// - faster signal holds up, slower holds down
// - equal frequency: lag interval drives down or up
// - phase and frequency match: both drivers off
// - phase pulse output high while locked
package pllpc_pkg;
    localparam int PLLPC_STAGES = 4;
    localparam logic PLLPC_INHIBIT_ON = 1'h1;
    localparam logic PLLPC_RESET_LEVEL = 1'h0;
    // comparator two detector states
    typedef enum logic [1:0] {
        PLLPC_IDLE,
        PLLPC_UP,
        PLLPC_DOWN
    } pllpc_state_t;
endpackage

//--- rtl/pllpc_top.sv
// digital phase comparators of a phase-locked loop
`timescale 1ns/1ps
module pllpc_top (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic signal_in,
    input wire logic compare_in,
    input wire logic inhibit_in,
    output logic xor_out,
    output logic pc2_up_out,
    output logic pc2_down_out,
    output logic pc2_level_out,
    output logic pc2_oe_out,
    output logic lock_out,
    output logic osc_enable_out
);
    import pllpc_pkg::*;
    // input positions in the shared edge vectors, signal then comparator
    localparam int SIG_IDX = 0;
    localparam int CMP_IDX = 1;
    localparam int N_INPUTS = 2;
    // bit positions of the driver request
    localparam int DRV_UP = 1;
    localparam int DRV_DOWN = 0;
    logic [N_INPUTS-1:0] level_vec;
    logic [N_INPUTS-1:0] rise_vec;
    logic sig_rise;
    logic cmp_rise;
    logic [1:0] drv_d;
    pllpc_state_t state_q;
    pllpc_state_t state_d;
    genvar g;

    // map a detector state to its driver request, never both bits
    function automatic logic [1:0] pllpc_drv(input pllpc_state_t st);
        logic [1:0] drv;
        drv = 2'h0;
        unique case (st)
            PLLPC_IDLE: drv = 2'h0;
            PLLPC_UP: drv[DRV_UP] = 1'h1;
            PLLPC_DOWN: drv[DRV_DOWN] = 1'h1;
            default: drv = 2'h0; // unused code asks for no driver
        endcase
        return drv;
    endfunction

    // both comparators read the same two input paths
    assign level_vec = {compare_in, signal_in};

    // one rising-edge detector per shared input
    for (g = 0; g < N_INPUTS; g = g + 1) begin : g_edge
        pllpc_edge u_edge (
            .clock_in(clock_in),
            .reset_in(reset_in),
            .level_in(level_vec[g]),
            .rise_out(rise_vec[g])
        );
    end

    // name the strobes for the detector logic
    assign sig_rise = rise_vec[SIG_IDX];
    assign cmp_rise = rise_vec[CMP_IDX];

    // comparator one, registered
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            xor_out <= 1'h0;
        end else begin
            xor_out <= signal_in ^ compare_in;
        end
    end

    // tri-state phase frequency detector next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            PLLPC_IDLE: begin
                if (sig_rise && !cmp_rise) begin
                    state_d = PLLPC_UP;
                end else if (cmp_rise && !sig_rise) begin
                    state_d = PLLPC_DOWN;
                end
            end
            PLLPC_UP: begin
                if (cmp_rise && !sig_rise) begin
                    state_d = PLLPC_IDLE;
                end
            end
            PLLPC_DOWN: begin
                if (sig_rise && !cmp_rise) begin
                    state_d = PLLPC_IDLE;
                end
            end
            default: state_d = PLLPC_IDLE;
        endcase
    end

    // state register; faster input keeps its driver held on
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            state_q <= PLLPC_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // driver request of the state being entered
    assign drv_d = pllpc_drv(state_d);

    // drivers from the request; one-hot so never both on
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            pc2_up_out <= 1'h0;
            pc2_down_out <= 1'h0;
            pc2_oe_out <= 1'h0;
            pc2_level_out <= 1'h0;
        end else begin
            pc2_up_out <= drv_d[DRV_UP];
            pc2_down_out <= drv_d[DRV_DOWN];
            pc2_oe_out <= |drv_d;
            pc2_level_out <= drv_d[DRV_UP];
        end
    end

    // lock indicator high while no driver active
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            lock_out <= 1'h0;
        end else begin
            lock_out <= ~|drv_d;
        end
    end

    // oscillator enable from inhibit
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            osc_enable_out <= 1'h0;
        end else begin
            osc_enable_out <= (inhibit_in != PLLPC_INHIBIT_ON);
        end
    end
endmodule

//--- testbench/pllpc_chk.sv
// port checks for the phase comparators
`timescale 1ns/1ps
module pllpc_chk (input wire logic clock_in, reset_in, signal_in, compare_in,
    inhibit_in, xor_out, pc2_up_out, pc2_down_out, pc2_level_out, pc2_oe_out,
    lock_out, osc_enable_out);
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);
    property p_x; $past(!reset_in) |-> xor_out==$past(signal_in^compare_in);
    endproperty
    a_x: assert property (p_x) else $error("xor");
    property p_o; $past(!reset_in) |-> osc_enable_out==!$past(inhibit_in);
    endproperty
    a_o: assert property (p_o) else $error("osc");
    property p_e; !(pc2_up_out && pc2_down_out); endproperty
    a_e: assert property (p_e) else $error("both");
    property p_l; $past(!reset_in) |-> lock_out==!(pc2_up_out||pc2_down_out);
    endproperty
    a_l: assert property (p_l) else $error("lock");
    property p_z; pc2_oe_out == (pc2_up_out || pc2_down_out); endproperty
    a_z: assert property (p_z) else $error("oe");
    property p_v; pc2_oe_out |-> pc2_level_out == pc2_up_out; endproperty
    a_v: assert property (p_v) else $error("level");
    sequence s_su; $rose(signal_in) && !$rose(compare_in); endsequence
    property p_u; s_su ##0 !pc2_down_out |=> pc2_up_out; endproperty
    a_u: assert property (p_u) else $error("up");
    property p_d; $rose(compare_in) && !$rose(signal_in) && !pc2_up_out
        |=> pc2_down_out; endproperty
    a_d: assert property (p_d) else $error("down");
    property p_r; !$past(reset_in) && ($rose(signal_in) == $rose(compare_in))
        |=> $stable(pc2_up_out) && $stable(pc2_down_out); endproperty
    a_r: assert property (p_r) else $error("refused");
endmodule
bind pllpc_top pllpc_chk u_chk (.clock_in(clock_in), .reset_in(reset_in),
    .signal_in(signal_in), .compare_in(compare_in), .inhibit_in(inhibit_in),
    .xor_out(xor_out), .pc2_up_out(pc2_up_out), .pc2_down_out(pc2_down_out),
    .pc2_level_out(pc2_level_out), .pc2_oe_out(pc2_oe_out),
    .lock_out(lock_out), .osc_enable_out(osc_enable_out));

//--- testbench/pllpc_src.sv
// square wave source for one comparator input
`timescale 1ns/1ps
module pllpc_src (input wire logic clock_in, input wire logic en_in,
    input wire logic [3:0] half_in, output logic wave_out = 0);
    int n = 0;
    logic en_q = 1'h0;
    // even duty wave, held low while disabled; enable taken at the edge
    always @(posedge clock_in) begin
        en_q = en_in;
        #2;
        if (!en_q) begin
            n = 0;
            wave_out = 1'h0;
        end else if (n + 1 >= half_in) begin
            n = 0;
            wave_out = ~wave_out;
        end else begin
            n = n + 1;
        end
    end
endmodule

//--- testbench/pllpc_tb_top.sv
// bench for the phase comparators
`timescale 1ns/1ps
module pllpc_tb_top;
    logic clock_in = 0, reset_in, inhibit_in = 0, es, ec, s, c, up, dn, lk, osc;
    logic xr, oe, lv;
    logic [3:0] hs, hc;
    logic [31:0] nu, nd, nl, nx, no, nv;
    int failures = 0, n_compared = 0;
    initial forever #12.5 clock_in = ~clock_in;
    pllpc_src u_s (.clock_in, .en_in(es), .half_in(hs), .wave_out(s));
    pllpc_src u_c (.clock_in, .en_in(ec), .half_in(hc), .wave_out(c));
    pllpc_top u_dut (.clock_in, .reset_in, .signal_in(s), .compare_in(c),
        .inhibit_in, .xor_out(xr), .pc2_up_out(up), .pc2_down_out(dn),
        .pc2_level_out(lv), .pc2_oe_out(oe), .lock_out(lk),
        .osc_enable_out(osc));
    task chk(string m, logic [31:0] v, e);
        n_compared++;
        if (v !== e) $display("CHECK FAILED %s expected %0d seen %0d", m, e, v);
        failures += (v !== e);
    endtask
    // reset, start signal, start comparator g cycles later, tally 120 cycles
    task go(logic [3:0] a, b, int g);
        {es, ec, reset_in, hs, hc} = {3'h1, a, b};
        {nu, nd, nl, nx, no, nv} = 192'h0;
        for (int i = 0; i < g + 122; i++) begin
            @(posedge clock_in) #2;
            if (i == 1) {reset_in, es} = 2'h1;
            if (i == g + 1) ec = 1;
            if (i > g + 1) begin
                {nu, nd, nl} = {nu + up, nd + dn, nl + lk};
                {nx, no, nv} = {nx + xr, no + oe, nv + lv};
            end
        end
    endtask
    task t_fast;
        go(4'h2, 4'h5, 0);
        chk("fast down", nd, 0);
        chk("fast up", nu > 60, 1);
        chk("osc on", osc, 1);
    endtask
    task t_slow;
        go(4'h5, 4'h2, 0);
        chk("slow up", nu, 0);
        chk("slow down", nd > 60, 1);
    endtask
    task t_lock;
        inhibit_in = 1;
        go(4'h3, 4'h3, 0);
        chk("locked", nl, 120);
        chk("drivers", nu + nd, 0);
        chk("osc off", osc, 0);
        chk("lock xor", nx, 0);
        chk("lock oe", no, 0);
        inhibit_in = 0;
    endtask
    task t_lead;
        go(4'h3, 4'h3, 2);
        chk("lead down", nd, 0);
        chk("lead up", nu > 20 && nu < 60, 1);
        chk("lead up count", nu, 40);
        chk("lead xor", nx, 80);
        chk("lead oe", no, 40);
        chk("lead level", nv, 40);
    endtask
    task conclude;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        t_fast;
        t_slow;
        t_lock;
        t_lead;
        conclude;
    end
endmodule
